// file: common/async_serial_receiver_ctrl_regs.vh
// Register map, field positions, reset values and sample timing of the serial receiver control
`ifndef ASYNC_SERIAL_RECEIVER_CTRL_REGS_VH
`define ASYNC_SERIAL_RECEIVER_CTRL_REGS_VH
// ************************************************
// Register offsets
// ************************************************
`define OFS_CONTROL_ONE 3'h0
`define OFS_CONTROL_TWO 3'h1
`define OFS_CONTROL_THREE 3'h2
`define OFS_STATUS_ONE 3'h3
`define OFS_RX_DATA 3'h4
`define OFS_BREAK_CTRL 3'h5
`define OFS_BAUD_DIV 3'h6
// ************************************************
// Control one fields
// ************************************************
`define C1_ECHO 7
`define C1_ENABLE 6
`define C1_INVERT 5
`define C1_LONG 4
`define C1_WAKE_ADDR 3
`define C1_IDLE_AFTER_STOP 2
`define C1_PAR_EN 1
`define C1_PAR_ODD 0
// ************************************************
// Control two fields
// ************************************************
`define C2_TXE_IE 7
`define C2_TC_IE 6
`define C2_RXF_IE 5
`define C2_IDLE_IE 4
`define C2_TX_EN 3
`define C2_RX_EN 2
`define C2_STANDBY 1
`define C2_SEND_BRK 0
// ************************************************
// Control three fields
// ************************************************
`define C3_BIT8_RX 7
`define C3_BIT8_TX 6
`define C3_OVR_IE 3
`define C3_NOISE_IE 2
`define C3_FRAME_IE 1
`define C3_PAR_IE 0
// ************************************************
// Status one fields
// ************************************************
`define S1_TXE 7
`define S1_TC 6
`define S1_RXF 5
`define S1_IDLE 4
`define S1_OVR 3
`define S1_NOISE 2
`define S1_FRAME 1
`define S1_PAR 0
`define BFC_CLEAR_EN 7
// ************************************************
// Reset values
// ************************************************
`define RST_BYTE 8'h00
`define RST_BAUD_DIV 8'h0c
`define RST_HIST 3'h0
// ************************************************
// Sample tick positions within one bit
// ************************************************
`define RT_EDGE_NEXT 5'h02
`define RT_WRAP 5'h01
`define RT_START_A 5'h03
`define RT_START_B 5'h05
`define RT_START_C 5'h07
`define RT_BIT_A 5'h08
`define RT_BIT_B 5'h09
`define RT_BIT_C 5'h0a
`define RT_LAST 5'h10
`define RT_STEP 5'h01
`define BITS_SHORT 4'h8
`define BITS_LONG 4'h9
`define IDLE_TICKS_SHORT 8'ha0
`define IDLE_TICKS_LONG 8'hb0
`define HIST_ONES 3'h7
`endif

// file: design/async_serial_receiver_ctrl.v
// Receiver control of the serial communications unit with register port and pin takeover
// Operation
// (RULE_01) A divider makes a sample tick at sixteen times baud; all line sampling uses it.
// (RULE_02) Start bit checked at ticks 3,5,7 after 1-1-1-0; zero majority accepts; disagreement is noise.
// (RULE_03) Each data bit is the majority of ticks 8,9,10; disagreement sets noise.
// (RULE_04) Ones at ticks 8-10 of an accepted start bit set noise, bit stays a start.
// (RULE_05) Stop bit sampled at ticks 8,9,10 for checking and noise.
// (RULE_06) Zero majority in stop samples sets framing error; disagreement sets noise.
// (RULE_07) No one in stop position, breaks included, sets framing error.
// (RULE_08) Framing error rises in the same cycle as receive-full.
// (RULE_09) Valid falling edges inside a character realign the tick counter.
// (RULE_10) Standby bit set by software suppresses receiver interrupts until a wake clears it.
// (RULE_11) Address wake: character with MSB one clears standby and sets receive-full.
// (RULE_12) Idle wake: idle character clears standby, sets neither idle nor receive-full.
// (RULE_13) Idle counting of ones starts after start bit or after stop bit, selectable.
// (RULE_14) Idle wake: setting standby on an already idle line wakes at once.
// (RULE_15) Character into data buffer sets receive-full; its enable gates the receiver interrupt.
// (RULE_16) Idle flag after 10 or 11 bit times of ones; idle enable gates interrupt.
// (RULE_17) New character while full sets overrun, keeps old data; overrun enable gates error interrupt.
// (RULE_18) Noise in any start, data or stop bit sets noise flag; enable gates error interrupt.
// (RULE_19) Parity mismatch sets parity flag; framing and parity enables gate error interrupt.
// (RULE_20) The unit keeps running in wait mode so enabled interrupts can wake the processor.
// (RULE_21) Stop mode freezes all logic with registers kept; resumes after. Code freezes only the tick divider, receive sequencer and idle counter.
// (RULE_22) In debug break without clear enable, accesses leave flags; armed two-step clears finish later.
// (RULE_23) Enabled unit forces transmit pin to output and receive pin to input.
// (RULE_24) Loopback feeds transmitter output to receiver instead of the pin; reset clears it.
// (RULE_25) Module enable gates unit and divider; cleared sets transmit flags, masks transmit interrupts.
// (RULE_26) Transmit inversion flips every transmitted bit; reset leaves it off.
// (RULE_27) Receive-full and idle form one receiver interrupt, four errors one error interrupt.
`include "async_serial_receiver_ctrl_regs.vh"

module async_serial_receiver_ctrl #(
	parameter DIV_WIDTH = 8
) (
	input wire core_clk,
	input wire rst,
	input wire [2:0] addr,
	input wire [7:0] wr_data,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rd_data,
	input wire rxd_pin_in,
	output reg rxd_pin_out,
	output reg rxd_pin_oe_n,
	output reg txd_pin_out,
	output reg txd_pin_oe_n,
	input wire port_out_tx,
	input wire port_out_rx,
	input wire port_dir_tx,
	input wire port_dir_rx,
	input wire tx_serial,
	input wire tx_empty_in,
	input wire tx_done_in,
	output wire tx_enable,
	output wire send_break,
	output wire tx_bit8,
	input wire dbg_break,
	input wire stop_mode,
	output wire rx_irq,
	output wire err_irq,
	output wire tx_irq
);

	localparam [3:0] ST_HUNT = 4'b0001;
	localparam [3:0] ST_START = 4'b0010;
	localparam [3:0] ST_DATA = 4'b0100;
	localparam [3:0] ST_STOP = 4'b1000;

	// Majority of three samples
	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	// Three samples not all equal
	function dis3;
		input a;
		input b;
		input c;
		begin
			dis3 = (a != b) | (a != c);
		end
	endfunction

	reg [7:0] ctrl_one_reg;
	reg [7:0] ctrl_two_reg;
	reg [7:0] ctrl_three_reg;
	reg [7:0] break_ctrl_reg;
	reg [DIV_WIDTH-1:0] baud_div_reg;
	reg [DIV_WIDTH-1:0] div_cnt_reg;
	reg tick_reg;
	reg [7:0] rx_buf_reg;
	reg bit8_rx_reg;
	reg rxf_reg, idle_reg, ovr_reg, noise_reg, frame_reg, par_reg;
	reg txe_reg, tc_reg;
	reg [5:0] arm_reg;
	reg rxd_meta_reg, rxd_sync_reg;
	reg [3:0] state_reg;
	reg [4:0] rt_reg;
	reg [2:0] hist_reg;
	reg [1:0] smp_reg;
	reg [3:0] bitcnt_reg;
	reg [8:0] shift_reg;
	reg noise_acc_reg;
	reg prev_bit_reg;
	reg done_reg;
	reg done_noise_reg;
	reg done_frame_reg;
	reg [8:0] done_data_reg;
	reg [7:0] idle_cnt_reg;
	reg idle_evt_reg;

	wire enable = ctrl_one_reg[`C1_ENABLE];
	wire run = ~stop_mode; // [RULE_21]
	wire long_char = ctrl_one_reg[`C1_LONG];
	wire wake_addr = ctrl_one_reg[`C1_WAKE_ADDR];
	wire standby = ctrl_two_reg[`C2_STANDBY];
	wire rx_on = enable & ctrl_two_reg[`C2_RX_EN];
	wire protect = dbg_break & ~break_ctrl_reg[`BFC_CLEAR_EN];
	wire tx_line = tx_serial ^ ctrl_one_reg[`C1_INVERT]; // [RULE_26]
	wire rx_src = ctrl_one_reg[`C1_ECHO] ? tx_line : rxd_sync_reg; // [RULE_24]
	wire [3:0] nbits = long_char ? `BITS_LONG : `BITS_SHORT;
	wire [7:0] idle_target = long_char ? `IDLE_TICKS_LONG : `IDLE_TICKS_SHORT;
	wire step = tick_reg & rx_on & run;
	wire wr_c1 = wr_stb & (addr == `OFS_CONTROL_ONE);
	wire wr_c2 = wr_stb & (addr == `OFS_CONTROL_TWO);
	wire rd_status = rd_stb & (addr == `OFS_STATUS_ONE);
	wire rd_buf = rd_stb & (addr == `OFS_RX_DATA);
	wire done_msb = long_char ? done_data_reg[8] : done_data_reg[7];
	wire idle_line = idle_cnt_reg >= idle_target;
	wire [4:0] rt_inc = rt_reg + `RT_STEP;

	// ************************************************
	// Pin synchroniser and pin takeover
	// ************************************************

	// Two-stage synchroniser on the receive pin
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= rxd_pin_in;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	// Pin drive, direction forced while enabled
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txd_pin_out <= 1'b1;
			txd_pin_oe_n <= 1'b1;
			rxd_pin_out <= 1'b0;
			rxd_pin_oe_n <= 1'b1;
		end else begin
			txd_pin_out <= enable ? tx_line : port_out_tx; // [RULE_26]
			txd_pin_oe_n <= enable ? 1'b0 : ~port_dir_tx; // [RULE_23]
			rxd_pin_out <= port_out_rx;
			rxd_pin_oe_n <= enable ? 1'b1 : ~port_dir_rx; // [RULE_23]
		end
	end

	// ************************************************
	// Sample tick divider
	// ************************************************

	// Tick pulse every baud_div+1 cycles, gated by enable
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt_reg <= {DIV_WIDTH{1'b0}};
			tick_reg <= 1'b0;
		end else if (!enable) begin
			div_cnt_reg <= {DIV_WIDTH{1'b0}}; // [RULE_25]
			tick_reg <= 1'b0;
		end else if (run) begin
			tick_reg <= (div_cnt_reg == {DIV_WIDTH{1'b0}}); // [RULE_01]
			div_cnt_reg <= (div_cnt_reg == {DIV_WIDTH{1'b0}}) ? baud_div_reg : div_cnt_reg - 1'b1;
		end
	end

	// ************************************************
	// Receive sequencer
	// ************************************************

	// Hunt, start check, data and stop sampling per tick
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_HUNT;
			rt_reg <= `RT_WRAP;
			hist_reg <= `RST_HIST;
			smp_reg <= 2'b00;
			bitcnt_reg <= 4'h0;
			shift_reg <= 9'h000;
			noise_acc_reg <= 1'b0;
			prev_bit_reg <= 1'b0;
			done_reg <= 1'b0;
			done_noise_reg <= 1'b0;
			done_frame_reg <= 1'b0;
			done_data_reg <= 9'h000;
		end else if (!rx_on) begin
			state_reg <= ST_HUNT;
			hist_reg <= `RST_HIST;
			done_reg <= 1'b0;
		end else if (!run) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (step) begin
				hist_reg <= {hist_reg[1:0], rx_src};
				if (rt_reg == `RT_BIT_A || rt_reg == `RT_START_A)
					smp_reg[0] <= rx_src;
				if (rt_reg == `RT_BIT_B || rt_reg == `RT_START_B)
					smp_reg[1] <= rx_src;
				case (state_reg)
					ST_HUNT: begin
						if (hist_reg == `HIST_ONES && !rx_src) begin
							state_reg <= ST_START;
							rt_reg <= `RT_EDGE_NEXT;
							noise_acc_reg <= 1'b0;
						end
					end
					ST_START: begin
						rt_reg <= (rt_reg == `RT_LAST) ? `RT_WRAP : rt_inc;
						if (rt_reg == `RT_START_C) begin
							if (maj3(smp_reg[0], smp_reg[1], rx_src)) begin // [RULE_02]
								state_reg <= ST_HUNT;
								hist_reg <= `RST_HIST;
							end else if (dis3(smp_reg[0], smp_reg[1], rx_src)) begin
								noise_acc_reg <= 1'b1; // [RULE_02]
							end
						end
						// Late ones only flag noise, acceptance stands
						if ((rt_reg == `RT_BIT_A || rt_reg == `RT_BIT_B || rt_reg == `RT_BIT_C) && rx_src)
							noise_acc_reg <= 1'b1; // [RULE_04]
						if (rt_reg == `RT_LAST) begin
							state_reg <= ST_DATA;
							bitcnt_reg <= 4'h0;
							prev_bit_reg <= 1'b0;
						end
					end
					ST_DATA: begin
						rt_reg <= (rt_reg == `RT_LAST) ? `RT_WRAP : rt_inc;
						if (rt_reg == `RT_BIT_C) begin
							prev_bit_reg <= maj3(smp_reg[0], smp_reg[1], rx_src); // [RULE_03]
							shift_reg <= {maj3(smp_reg[0], smp_reg[1], rx_src), shift_reg[8:1]};
							if (dis3(smp_reg[0], smp_reg[1], rx_src))
								noise_acc_reg <= 1'b1; // [RULE_03]
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end
						// Edge after a one bit, outside the sample window
						if (prev_bit_reg && hist_reg[0] && !rx_src && (rt_reg > `RT_BIT_C || rt_reg < `RT_BIT_A))
							rt_reg <= `RT_EDGE_NEXT; // [RULE_09]
						if (rt_reg == `RT_LAST && bitcnt_reg == nbits)
							state_reg <= ST_STOP;
					end
					ST_STOP: begin
						rt_reg <= rt_inc;
						if (rt_reg == `RT_BIT_C) begin // [RULE_05]
							state_reg <= ST_HUNT;
							done_reg <= 1'b1;
							done_frame_reg <= ~maj3(smp_reg[0], smp_reg[1], rx_src); // [RULE_06] [RULE_07]
							done_noise_reg <= noise_acc_reg | dis3(smp_reg[0], smp_reg[1], rx_src); // [RULE_06]
							done_data_reg <= long_char ? shift_reg : {1'b0, shift_reg[8:1]};
						end
					end
					default: begin
						state_reg <= ST_HUNT;
					end
				endcase
			end
		end
	end

	// ************************************************
	// Idle line counter
	// ************************************************

	// Counts high ticks; in after-stop mode only while hunting
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idle_cnt_reg <= 8'h00;
			idle_evt_reg <= 1'b0;
		end else if (!rx_on) begin
			idle_cnt_reg <= 8'h00;
			idle_evt_reg <= 1'b0;
		end else begin
			idle_evt_reg <= 1'b0;
			if (step) begin
				if (!rx_src || (ctrl_one_reg[`C1_IDLE_AFTER_STOP] && state_reg != ST_HUNT)) begin
					idle_cnt_reg <= 8'h00; // [RULE_13]
				end else if (!idle_line) begin
					idle_cnt_reg <= idle_cnt_reg + 8'h01;
					idle_evt_reg <= (idle_cnt_reg == idle_target - 8'h01); // [RULE_16]
				end
			end
		end
	end

	// ************************************************
	// Register writes and control state
	// ************************************************

	// Software control writes and hardware wake of standby
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_one_reg <= `RST_BYTE; // [RULE_24] [RULE_25] [RULE_26]
			ctrl_two_reg <= `RST_BYTE;
			ctrl_three_reg <= `RST_BYTE;
			break_ctrl_reg <= `RST_BYTE;
			baud_div_reg <= `RST_BAUD_DIV;
		end else begin
			if (wr_c1)
				ctrl_one_reg <= wr_data;
			if (wr_c2) begin
				ctrl_two_reg <= wr_data;
				// Transmit and receive enables are locked while the unit is off
				if (!enable) begin
					ctrl_two_reg[`C2_TX_EN] <= ctrl_two_reg[`C2_TX_EN];
					ctrl_two_reg[`C2_RX_EN] <= ctrl_two_reg[`C2_RX_EN];
				end
			end else if (standby && done_reg && wake_addr && done_msb) begin
				ctrl_two_reg[`C2_STANDBY] <= 1'b0; // [RULE_11]
			end else if (standby && !wake_addr && rx_on && idle_line) begin
				ctrl_two_reg[`C2_STANDBY] <= 1'b0; // [RULE_12] [RULE_14]
			end
			if (wr_stb && addr == `OFS_CONTROL_THREE)
				ctrl_three_reg <= wr_data;
			if (wr_stb && addr == `OFS_BREAK_CTRL)
				break_ctrl_reg <= wr_data;
			if (wr_stb && addr == `OFS_BAUD_DIV)
				baud_div_reg <= wr_data[DIV_WIDTH-1:0];
		end
	end

	// ************************************************
	// Status flags, data buffer and two-step clear
	// ************************************************

	wire take = done_reg & (~standby | (wake_addr & done_msb)); // [RULE_10] [RULE_11]
	wire load = take & ~rxf_reg;
	wire par_bad = ctrl_one_reg[`C1_PAR_EN] & ((^done_data_reg) != ctrl_one_reg[`C1_PAR_ODD]);
	wire clr = rd_buf & ~protect; // [RULE_22]

	// Flags set by events win over a clear in the same cycle
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxf_reg <= 1'b0;
			idle_reg <= 1'b0;
			ovr_reg <= 1'b0;
			noise_reg <= 1'b0;
			frame_reg <= 1'b0;
			par_reg <= 1'b0;
			arm_reg <= 6'h00;
			rx_buf_reg <= `RST_BYTE;
			bit8_rx_reg <= 1'b0;
			txe_reg <= 1'b1;
			tc_reg <= 1'b1;
		end else begin
			rxf_reg <= (rxf_reg & ~(clr & arm_reg[`S1_RXF])) | load; // [RULE_15] [RULE_08]
			idle_reg <= (idle_reg & ~(clr & arm_reg[`S1_IDLE])) | (idle_evt_reg & ~standby); // [RULE_12] [RULE_16]
			ovr_reg <= (ovr_reg & ~(clr & arm_reg[`S1_OVR])) | (take & rxf_reg); // [RULE_17]
			noise_reg <= (noise_reg & ~(clr & arm_reg[`S1_NOISE])) | (take & done_noise_reg); // [RULE_18]
			frame_reg <= (frame_reg & ~(clr & arm_reg[`S1_FRAME])) | (take & done_frame_reg); // [RULE_08]
			par_reg <= (par_reg & ~(clr & arm_reg[`S1_PAR])) | (take & par_bad); // [RULE_19]
			// First step arms, protected reads leave the arming as it was
			if (clr)
				arm_reg <= 6'h00;
			else if (rd_status && !protect)
				arm_reg <= {rxf_reg, idle_reg, ovr_reg, noise_reg, frame_reg, par_reg}; // [RULE_22]
			if (load) begin
				rx_buf_reg <= done_data_reg[7:0]; // [RULE_17]
				bit8_rx_reg <= done_msb;
			end
			txe_reg <= enable ? tx_empty_in : 1'b1; // [RULE_25]
			tc_reg <= enable ? tx_done_in : 1'b1; // [RULE_25]
		end
	end

	// ************************************************
	// Read port and interrupt requests
	// ************************************************

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data <= `RST_BYTE;
		end else if (!rd_stb) begin
			rd_data <= `RST_BYTE;
		end else begin
			case (addr)
				`OFS_CONTROL_ONE: rd_data <= ctrl_one_reg;
				`OFS_CONTROL_TWO: rd_data <= ctrl_two_reg;
				`OFS_CONTROL_THREE: rd_data <= {bit8_rx_reg, ctrl_three_reg[6], 2'b00, ctrl_three_reg[3:0]};
				`OFS_STATUS_ONE: rd_data <= {txe_reg, tc_reg, rxf_reg, idle_reg, ovr_reg, noise_reg, frame_reg, par_reg};
				`OFS_RX_DATA: rd_data <= rx_buf_reg;
				`OFS_BREAK_CTRL: rd_data <= {break_ctrl_reg[7], 7'h00};
				`OFS_BAUD_DIV: rd_data <= baud_div_reg;
				default: rd_data <= `RST_BYTE;
			endcase
		end
	end

	// Interrupt requests stay live in wait mode
	assign rx_irq = ~standby & ((rxf_reg & ctrl_two_reg[`C2_RXF_IE]) | (idle_reg & ctrl_two_reg[`C2_IDLE_IE])); // [RULE_10] [RULE_27] [RULE_20]
	assign err_irq = (ovr_reg & ctrl_three_reg[`C3_OVR_IE]) | (noise_reg & ctrl_three_reg[`C3_NOISE_IE])
		| (frame_reg & ctrl_three_reg[`C3_FRAME_IE]) | (par_reg & ctrl_three_reg[`C3_PAR_IE]); // [RULE_19] [RULE_27]
	assign tx_irq = enable & ((txe_reg & ctrl_two_reg[`C2_TXE_IE]) | (tc_reg & ctrl_two_reg[`C2_TC_IE])); // [RULE_25]
	assign tx_enable = ctrl_two_reg[`C2_TX_EN];
	assign send_break = ctrl_two_reg[`C2_SEND_BRK];
	assign tx_bit8 = ctrl_three_reg[`C3_BIT8_TX];

endmodule // async_serial_receiver_ctrl

// file: dv/serial_line_sender.sv
// Remote serial transmitter model on the receive line
module serial_line_sender #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic core_clk,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ******
	// Frame sender
	// ******
	// Line idles high between frames
	initial line = 1'b1;
	// Start, n bits LSB first, stop level s; bit g gets a one-cycle glitch mid-bit
	task automatic send(input logic [8:0] d, input int n, input logic s, input int g);
		logic b;
		for (int i = -1; i <= n; i++) begin
			for (int k = 0; k < BIT_CYCLES; k++) begin
				@(posedge core_clk);
				b = (i < 0) ? 1'b0 : (i == n) ? s : d[i];
				line <= b ^ (i == g && k == BIT_CYCLES / 2);
			end
		end
		@(posedge core_clk);
		line <= 1'b1;
	endtask
endmodule // serial_line_sender

// file: dv/rx_ctrl_checker_assertions.sv
// Port checker for the serial receiver control
`include "async_serial_receiver_ctrl_regs.vh"
module rx_ctrl_checker (
	input wire core_clk,
	input wire rst,
	input wire [2:0] addr,
	input wire rd_stb,
	input wire [7:0] rd_data,
	input wire rxd_pin_out,
	input wire rxd_pin_oe_n,
	input wire txd_pin_out,
	input wire txd_pin_oe_n,
	input wire port_out_tx,
	input wire port_out_rx,
	input wire port_dir_tx,
	input wire port_dir_rx,
	input wire tx_irq
);
	// ******
	// Properties
	// ******
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Pin ownership
	property p_tx_port;
		!$past(rst) && txd_pin_oe_n |-> txd_pin_out == $past(port_out_tx) && !$past(port_dir_tx);
	endproperty
	a_tx_port: assert property (p_tx_port) else $error("transmit pin not under port control");
	property p_rx_port;
		!$past(rst) |-> rxd_pin_out == $past(port_out_rx);
	endproperty
	a_rx_port: assert property (p_rx_port) else $error("receive pin value not the port value");
	property p_rx_dir;
		!rxd_pin_oe_n |-> $past(port_dir_rx) && txd_pin_oe_n == !$past(port_dir_tx);
	endproperty
	a_rx_dir: assert property (p_rx_dir) else $error("receive pin driven while unit enabled");
	property p_takeover;
		!txd_pin_oe_n && !$past(port_dir_tx) |-> rxd_pin_oe_n;
	endproperty
	a_takeover: assert property (p_takeover) else $error("pins not taken over together");
	property p_tx_irq;
		$past(tx_irq) |-> !txd_pin_oe_n;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt while unit disabled");
	// Register read port
	property p_dis_status;
		$past(rd_stb) && $past(addr) == `OFS_STATUS_ONE && $past(rxd_pin_oe_n) == 1'b0
			|-> rd_data[`S1_TXE:`S1_TC] == 2'b11;
	endproperty
	a_dis_status: assert property (p_dis_status) else $error("transmit flags not set while disabled");
	property p_rd_quiet;
		!$past(rd_stb) |-> rd_data == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read cycle");
	property p_unmapped;
		rd_stb && addr == 3'h7 |=> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // rx_ctrl_checker
bind async_serial_receiver_ctrl rx_ctrl_checker i_rx_ctrl_checker (
	.core_clk(core_clk),
	.rst(rst),
	.addr(addr),
	.rd_stb(rd_stb),
	.rd_data(rd_data),
	.rxd_pin_out(rxd_pin_out),
	.rxd_pin_oe_n(rxd_pin_oe_n),
	.txd_pin_out(txd_pin_out),
	.txd_pin_oe_n(txd_pin_oe_n),
	.port_out_tx(port_out_tx),
	.port_out_rx(port_out_rx),
	.port_dir_tx(port_dir_tx),
	.port_dir_rx(port_dir_rx),
	.tx_irq(tx_irq)
);

// file: dv/testbench.sv
// Self-checking bench of the serial receiver control
`include "async_serial_receiver_ctrl_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, loop_sel = 0;
	logic [2:0] addr = 0;
	logic [7:0] wr_data = 0, rd_data, v;
	logic rxd_pin_out, rxd_pin_oe_n, txd_pin_out, txd_pin_oe_n, tx_enable, send_break, tx_bit8;
	logic rx_irq, err_irq, tx_irq, ser;
	logic port_out_tx = 1, port_out_rx = 0, port_dir_tx = 0, port_dir_rx = 0, dbg_break = 0, stop_mode = 0, tx_in = 1;
	wire rxd_pin_in = loop_sel ? 1'b0 : ser;
	wire tx_serial = loop_sel ? ser : 1'b1;
	int fails = 0, tests_run = 0, n;
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h0c, 8'h00};
	logic [7:0] rm [8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff};
	// Clock
	always #2.5 core_clk = ~core_clk;
	async_serial_receiver_ctrl i_async_serial_receiver_ctrl (.core_clk(core_clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rxd_pin_in(rxd_pin_in),
		.rxd_pin_out(rxd_pin_out), .rxd_pin_oe_n(rxd_pin_oe_n), .txd_pin_out(txd_pin_out),
		.txd_pin_oe_n(txd_pin_oe_n), .port_out_tx(port_out_tx), .port_out_rx(port_out_rx),
		.port_dir_tx(port_dir_tx), .port_dir_rx(port_dir_rx), .tx_serial(tx_serial), .tx_empty_in(tx_in),
		.tx_done_in(tx_in), .tx_enable(tx_enable), .send_break(send_break), .tx_bit8(tx_bit8),
		.dbg_break(dbg_break), .stop_mode(stop_mode), .rx_irq(rx_irq), .err_irq(err_irq), .tx_irq(tx_irq));
	serial_line_sender i_serial_line_sender (.core_clk(core_clk), .line(ser));
	// ******
	// Bus and check tasks
	// ******
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rck(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		rd(a, v);
		chk(nm, v & m, e);
	endtask
	task clr;
		rd(`OFS_STATUS_ONE, v);
		rd(`OFS_RX_DATA, v);
	endtask
	task snd(input logic [8:0] d, input int nb = 8, input logic s = 1, input int g = 99);
		i_serial_line_sender.send(d, nb, s, g);
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ******
	// Scenarios
	// ******
	task t_pins;
		@(posedge core_clk);
		port_dir_tx <= 1'b1;
		port_dir_rx <= 1'b1;
		port_out_tx <= 1'b0;
		port_out_rx <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk("tx pin as port", {txd_pin_oe_n, txd_pin_out}, 8'h00);
		wr(`OFS_CONTROL_ONE, 8'h60);
		wr(`OFS_CONTROL_TWO, 8'h80);
		#1 chk("pins enabled", {rxd_pin_oe_n, txd_pin_oe_n, txd_pin_out, tx_irq}, 8'h09);
		@(posedge core_clk) tx_in <= 1'b0;
		rck(`OFS_STATUS_ONE, 8'hc0, 8'h00, "tx flags follow");
		wr(`OFS_CONTROL_ONE, 8'h00);
		rck(`OFS_STATUS_ONE, 8'hc0, 8'hc0, "tx flags");
		chk("tx irq off", tx_irq, 8'h00);
		@(posedge core_clk);
		port_dir_tx <= 1'b0;
		port_dir_rx <= 1'b0;
		port_out_tx <= 1'b1;
		port_out_rx <= 1'b0;
		tx_in <= 1'b1;
		wr(`OFS_CONTROL_TWO, 8'h0c);
		rck(`OFS_CONTROL_TWO, 8'hff, 8'h00, "enables refused");
	endtask
	task t_rx;
		snd(9'h0a5);
		chk("irqs", {rx_irq, err_irq}, 8'h02);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he0, "status");
		rck(`OFS_RX_DATA, 8'hff, 8'ha5, "data");
		chk("irq cleared", rx_irq, 8'h00);
		snd(9'h000, 8, 0);
		chk("err irq", err_irq, 8'h01);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he2, "break status");
		rck(`OFS_RX_DATA, 8'hff, 8'h00, "break data");
		snd(9'h011);
		snd(9'h022);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he8, "overrun");
		rck(`OFS_RX_DATA, 8'hff, 8'h11, "kept data");
		for (int g = -1; g <= 8; g += 1 + (g == 0) * 7) begin
			snd(9'h05a, 8, 1, g);
			rck(`OFS_STATUS_ONE, 8'hef, 8'he4, "noise");
			rck(`OFS_RX_DATA, 8'hff, 8'h5a, "noisy data");
		end
	endtask
	task t_par;
		wr(`OFS_CONTROL_ONE, 8'h42);
		snd(9'h001);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he1, "parity bad");
		clr;
		snd(9'h003);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he0, "parity good");
		clr;
		wr(`OFS_CONTROL_ONE, 8'h48);
		wr(`OFS_CONTROL_TWO, 8'h2e);
		snd(9'h012);
		chk("standby irq", rx_irq, 8'h00);
		rck(`OFS_CONTROL_TWO, 8'hff, 8'h2e, "still standby");
		snd(9'h092);
		chk("wake irq", rx_irq, 8'h01);
		rck(`OFS_CONTROL_TWO, 8'hff, 8'h2c, "woken");
		rck(`OFS_RX_DATA, 8'hff, 8'h92, "address");
	endtask
	task t_misc;
		wr(`OFS_CONTROL_ONE, 8'h40);
		clr;
		snd(9'h033);
		rd(`OFS_STATUS_ONE, v);
		@(posedge core_clk) dbg_break <= 1'b1;
		rd(`OFS_RX_DATA, v);
		rck(`OFS_STATUS_ONE, 8'hef, 8'he0, "flag kept");
		@(posedge core_clk) dbg_break <= 1'b0;
		rd(`OFS_RX_DATA, v);
		rck(`OFS_STATUS_ONE, 8'hef, 8'hc0, "late clear");
		wr(`OFS_CONTROL_ONE, 8'hc0);
		@(posedge core_clk) loop_sel <= 1'b1;
		snd(9'h06c);
		@(posedge core_clk) loop_sel <= 1'b0;
		rck(`OFS_RX_DATA, 8'hff, 8'h6c, "loopback");
		wr(`OFS_CONTROL_ONE, 8'h40);
		clr;
		@(posedge core_clk) stop_mode <= 1'b1;
		snd(9'h055);
		@(posedge core_clk) stop_mode <= 1'b0;
		rck(`OFS_STATUS_ONE, 8'hef, 8'hc0, "stopped");
		rck(`OFS_CONTROL_TWO, 8'hff, 8'h2c, "kept");
		snd(9'h056);
		rck(`OFS_RX_DATA, 8'hff, 8'h56, "resumed");
	endtask
	task t_idle;
		wr(`OFS_CONTROL_TWO, 8'h1c);
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_CONTROL_ONE, m ? 8'h44 : 8'h40);
			snd(m ? 9'h0ff : 9'h000);
			clr;
			for (n = 0; n < 300 && rx_irq !== 1'b1; n++) @(posedge core_clk) #1;
			chk("idle delay", n > 100 && n < 200, 8'h01);
			rck(`OFS_STATUS_ONE, 8'hff, 8'hd0, "idle");
		end
		clr;
		wr(`OFS_CONTROL_ONE, 8'h40);
		wr(`OFS_CONTROL_TWO, 8'h1e);
		for (n = 0; n < 120; n++) begin
			rd(`OFS_CONTROL_TWO, v);
			if (v[`C2_STANDBY] === 1'b0) break;
		end
		chk("idle wake", v, 8'h1c);
		rck(`OFS_STATUS_ONE, 8'hff, 8'hc0, "no flags");
	endtask
	// Watchdog
	initial begin
		repeat (40000) @(posedge core_clk);
		fails++;
		summarize;
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rck(i[2:0], rm[i], rv[i], "reset value");
		t_pins;
		wr(`OFS_BAUD_DIV, 8'h00);
		wr(`OFS_CONTROL_ONE, 8'h40);
		wr(`OFS_CONTROL_TWO, 8'h2c);
		wr(`OFS_CONTROL_THREE, 8'h4f);
		#1 chk("tx controls", {tx_enable, send_break, tx_bit8}, 8'h05);
		t_rx;
		t_par;
		t_misc;
		t_idle;
		summarize;
	end
endmodule // testbench
